/* hdl/uiic_pkg.sv */
// Package holding offsets, field positions, reset values and timing constants of the block.
package uiic_pkg;
  localparam logic [2:0] UIIC_OFS_IDENT = 3'h2;
  localparam logic [2:0] UIIC_OFS_FIFOCTL = 3'h2;
  localparam logic [2:0] UIIC_OFS_LFC = 3'h3;
  localparam logic [7:0] UIIC_IDENT_RST = 8'h01;
  localparam logic [7:0] UIIC_LFC_RST = 8'h00;
  localparam int UIIC_FCR_EN_BIT = 0;
  localparam int UIIC_FCR_RXCLR_BIT = 1;
  localparam int UIIC_FCR_TXCLR_BIT = 2;
  localparam int UIIC_FCR_TRIG_LSB = 6;
  localparam int UIIC_IER_RDA_BIT = 0;
  localparam int UIIC_IER_THRE_BIT = 1;
  localparam int UIIC_IER_LS_BIT = 2;
  localparam int UIIC_IER_MS_BIT = 3;
  localparam logic [4:0] UIIC_TRIG_1 = 5'h01;
  localparam logic [4:0] UIIC_TRIG_4 = 5'h04;
  localparam logic [4:0] UIIC_TRIG_8 = 5'h08;
  localparam logic [4:0] UIIC_TRIG_14 = 5'h0E;
  localparam logic [3:0] UIIC_ID_NONE = 4'h1;
  localparam logic [3:0] UIIC_ID_LS = 4'h6;
  localparam logic [3:0] UIIC_ID_RDA = 4'h4;
  localparam logic [3:0] UIIC_ID_TMO = 4'hC;
  localparam logic [3:0] UIIC_ID_THRE = 4'h2;
  localparam logic [3:0] UIIC_ID_MS = 4'h0;
  localparam logic [2:0] UIIC_TMO_CHARS = 3'h4;
endpackage

/* hdl/uiic_evt_if.sv */
// Interface carrying one interrupt source's set, clear and pending flag.
`timescale 1ns/10ps
interface uiic_evt_if;
  logic set;
  logic clr;
  logic pend;
  modport ctl (output set, output clr, input pend);
  modport flag (input set, input clr, output pend);
endinterface

/* hdl/uiic_flag.sv */
// Sticky interrupt source flag where a set beats a clear.
`timescale 1ns/10ps
module uiic_flag
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  uiic_evt_if.flag evt
);
  logic state;
  logic next_state;

  always_comb
  begin
    next_state = state;
    if (evt.clr)
    begin
      next_state = 1'b0;
    end
    if (evt.set)
    begin
      next_state = 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      state <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign evt.pend = state;

  set_wins_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    evt.set |=> evt.pend) else $error("Flag lost a set event.");
endmodule

/* hdl/uiic_top.sv */
// Interrupt identity, FIFO control and line format registers of the serial port.
// Overview of operation
// RULE1: Transmit clear empties FIFO, self-clears, keeps shifter.
// RULE2: Trigger field picks 1, 4, 8, 14 bytes.
// RULE3: Priority: line status, data, holding empty, modem.
// RULE4: Identity frozen while its read is in progress.
// RULE5: Bit 0 low means pending; reset 01h.
// RULE6: Bit 3 only for timeout in FIFO mode.
// RULE7: Codes 1, 6, 4, C, 2, 0 per source.
// RULE8: Timeout after four idle character times.
// RULE9: Bits 7:6 mirror FIFO enable bit.
// RULE10: Line format field layout; resets to 00h.
// RULE11: Each source clears on its own access.
// RULE12: FIFO enable gates other control bits; clearing empties.
// RULE13: Data enable also gates the timeout interrupt.
// RULE14: Word length 00..11 means 5..8 bits.
`timescale 1ns/10ps
module uiic_top
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic [3:0] irq_enable_i,
  input wire logic line_err_i,
  input wire logic lsr_rd_i,
  input wire logic rx_push_i,
  input wire logic rx_pop_i,
  input wire logic [4:0] rx_count_i,
  input wire logic thr_empty_i,
  input wire logic thr_wr_i,
  input wire logic modem_chg_i,
  input wire logic msr_rd_i,
  input wire logic char_tick_i,
  output logic fifo_mode_o,
  output logic tx_fifo_clr_o,
  output logic rx_fifo_clr_o,
  output logic [4:0] rx_trigger_o,
  output logic rx_trig_hit_o,
  output logic divisor_access_select_o,
  output logic break_ctrl_o,
  output logic stick_parity_o,
  output logic parity_even_o,
  output logic parity_en_o,
  output logic stop_bits_o,
  output logic [3:0] data_bits_o,
  output logic irq_o
);
  logic [7:0] line_format_control;
  logic [7:0] next_lfc;
  logic fifo_enable_bit;
  logic next_fen;
  logic [1:0] trig_sel;
  logic [1:0] next_trig;
  logic tx_clr;
  logic next_tx_clr;
  logic rx_clr;
  logic next_rx_clr;
  logic [7:0] interrupt_identity;
  logic [7:0] next_ident;
  logic ident_rd_d;
  logic [2:0] idle_chars;
  logic [2:0] next_idle;
  logic tmo_pend;
  logic next_tmo;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic ident_rd;
  logic [3:0] cur_code;
  logic thre_served;
  logic thre_prev;
  logic trig_hit_prev;

  uiic_evt_if ls_evt();
  uiic_evt_if rda_evt();
  uiic_evt_if thre_evt();
  uiic_evt_if ms_evt();

  uiic_flag u_ls (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .evt(ls_evt));
  uiic_flag u_rda (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .evt(rda_evt));
  uiic_flag u_thre (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .evt(thre_evt));
  uiic_flag u_ms (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .evt(ms_evt));

  assign ident_rd = rd_i && (addr_i == uiic_pkg::UIIC_OFS_IDENT);

  // RULE2: threshold decode
  always_comb
  begin
    case (trig_sel)
      2'h0: rx_trigger_o = uiic_pkg::UIIC_TRIG_1;
      2'h1: rx_trigger_o = uiic_pkg::UIIC_TRIG_4;
      2'h2: rx_trigger_o = uiic_pkg::UIIC_TRIG_8;
      2'h3: rx_trigger_o = uiic_pkg::UIIC_TRIG_14;
      default: rx_trigger_o = uiic_pkg::UIIC_TRIG_1;
    endcase
  end
  assign rx_trig_hit_o = fifo_enable_bit ? (rx_count_i >= rx_trigger_o) : rx_count_i != 5'h00;

  // RULE11: per-source set and clear
  always_comb
  begin
    ls_evt.set = line_err_i;
    ls_evt.clr = lsr_rd_i;
    rda_evt.set = rx_trig_hit_o && !trig_hit_prev;
    rda_evt.clr = rx_pop_i || !rx_trig_hit_o;
    thre_evt.set = thr_empty_i && !thre_prev;
    thre_evt.clr = thr_wr_i || thre_served;
    ms_evt.set = modem_chg_i;
    ms_evt.clr = msr_rd_i;
  end

  assign thre_served = ident_rd_d && !ident_rd
    && (interrupt_identity[3:0] == uiic_pkg::UIIC_ID_THRE);

  // RULE8: idle character time counter for timeout
  always_comb
  begin
    next_idle = idle_chars;
    next_tmo = tmo_pend;
    if (rx_push_i || rx_pop_i || !fifo_enable_bit || rx_count_i == 5'h00)
    begin
      next_idle = 3'h0;
      next_tmo = 1'b0;
    end
    else if (char_tick_i && idle_chars != uiic_pkg::UIIC_TMO_CHARS)
    begin
      next_idle = idle_chars + 3'h1;
      if (idle_chars + 3'h1 == uiic_pkg::UIIC_TMO_CHARS)
      begin
        next_tmo = 1'b1;
      end
    end
  end

  // RULE3: priority select with source enables
  always_comb
  begin
    if (ls_evt.pend && irq_enable_i[uiic_pkg::UIIC_IER_LS_BIT])
    begin
      cur_code = uiic_pkg::UIIC_ID_LS;
    end
    else if (rda_evt.pend && irq_enable_i[uiic_pkg::UIIC_IER_RDA_BIT])
    begin
      cur_code = uiic_pkg::UIIC_ID_RDA;
    end
    // RULE13: data enable also gates timeout
    else if (tmo_pend && fifo_enable_bit && irq_enable_i[uiic_pkg::UIIC_IER_RDA_BIT])
    begin
      // RULE6: bit 3 only in FIFO mode timeout
      cur_code = uiic_pkg::UIIC_ID_TMO;
    end
    else if (thre_evt.pend && irq_enable_i[uiic_pkg::UIIC_IER_THRE_BIT])
    begin
      cur_code = uiic_pkg::UIIC_ID_THRE;
    end
    else if (ms_evt.pend && irq_enable_i[uiic_pkg::UIIC_IER_MS_BIT])
    begin
      cur_code = uiic_pkg::UIIC_ID_MS;
    end
    else
    begin
      // RULE5: no pending reads bit 0 high
      cur_code = uiic_pkg::UIIC_ID_NONE;
    end
  end

  // RULE4: hold identity during a read
  // RULE7: code placed in low nibble
  // RULE9: top bits mirror FIFO enable
  always_comb
  begin
    next_ident = interrupt_identity;
    if (!ident_rd)
    begin
      next_ident = {{2{fifo_enable_bit}}, 2'h0, cur_code};
    end
  end

  // RULE12: FIFO control write gating
  // RULE1: self-clearing FIFO clear pulses
  always_comb
  begin
    next_fen = fifo_enable_bit;
    next_trig = trig_sel;
    next_tx_clr = 1'b0;
    next_rx_clr = 1'b0;
    if (wr_i && addr_i == uiic_pkg::UIIC_OFS_FIFOCTL)
    begin
      next_fen = wdata_i[uiic_pkg::UIIC_FCR_EN_BIT];
      if (wdata_i[uiic_pkg::UIIC_FCR_EN_BIT])
      begin
        next_trig = wdata_i[uiic_pkg::UIIC_FCR_TRIG_LSB +: 2];
        next_tx_clr = wdata_i[uiic_pkg::UIIC_FCR_TXCLR_BIT];
        next_rx_clr = wdata_i[uiic_pkg::UIIC_FCR_RXCLR_BIT];
      end
      else
      begin
        next_tx_clr = 1'b1;
        next_rx_clr = 1'b1;
      end
    end
  end

  // RULE10: line format register storage
  always_comb
  begin
    next_lfc = line_format_control;
    if (wr_i && addr_i == uiic_pkg::UIIC_OFS_LFC)
    begin
      next_lfc = wdata_i;
    end
  end

  always_comb
  begin
    next_rdata = rdata;
    if (rd_i)
    begin
      case (addr_i)
        uiic_pkg::UIIC_OFS_IDENT: next_rdata = ident_rd_d ? interrupt_identity : next_ident;
        uiic_pkg::UIIC_OFS_LFC: next_rdata = line_format_control;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      line_format_control <= uiic_pkg::UIIC_LFC_RST;
      fifo_enable_bit <= 1'b0;
      trig_sel <= 2'h0;
      tx_clr <= 1'b0;
      rx_clr <= 1'b0;
      interrupt_identity <= uiic_pkg::UIIC_IDENT_RST;
      ident_rd_d <= 1'b0;
      idle_chars <= 3'h0;
      tmo_pend <= 1'b0;
      rdata <= 8'h00;
      thre_prev <= 1'b0;
      trig_hit_prev <= 1'b0;
    end
    else
    begin
      line_format_control <= next_lfc;
      fifo_enable_bit <= next_fen;
      trig_sel <= next_trig;
      tx_clr <= next_tx_clr;
      rx_clr <= next_rx_clr;
      interrupt_identity <= next_ident;
      ident_rd_d <= ident_rd;
      idle_chars <= next_idle;
      tmo_pend <= next_tmo;
      rdata <= next_rdata;
      thre_prev <= thr_empty_i;
      trig_hit_prev <= rx_trig_hit_o;
    end
  end

  assign rdata_o = rdata;
  assign fifo_mode_o = fifo_enable_bit;
  assign tx_fifo_clr_o = tx_clr;
  assign rx_fifo_clr_o = rx_clr;
  assign divisor_access_select_o = line_format_control[7];
  assign break_ctrl_o = line_format_control[6];
  assign stick_parity_o = line_format_control[5];
  assign parity_even_o = line_format_control[4];
  assign parity_en_o = line_format_control[3];
  assign stop_bits_o = line_format_control[2];
  // RULE14: word length to data bit count
  assign data_bits_o = 4'h5 + {2'h0, line_format_control[1:0]};
  assign irq_o = !interrupt_identity[0];

  ident_freeze_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE4
    ident_rd |=> $stable(interrupt_identity)) else $error("Identity changed during read.");
  tx_clr_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE1
    tx_clr |=> !tx_clr || $past(wr_i)) else $error("Transmit clear did not self-clear.");
  fifo_en_top_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE9
    interrupt_identity[7:6] == {2{$past(fifo_enable_bit)}} || $past(ident_rd))
    else $error("Identity top bits mismatch FIFO enable.");
  bit3_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE6
    interrupt_identity[3] |-> interrupt_identity[2] && $past(fifo_enable_bit))
    else $error("Bit 3 set outside a timeout.");
  ls_first_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE3
    ls_evt.pend && irq_enable_i[2] && !ident_rd |=> interrupt_identity[3:0] == 4'h6)
    else $error("Line status not reported first.");
  pend_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE5
    irq_o == (interrupt_identity[3:0] != 4'h1)) else $error("Pending bit inconsistent.");
  trig_map_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE2
    trig_sel == 2'h3 |-> rx_trigger_o == 5'h0E) else $error("Trigger level wrong.");
  lfc_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE10
    wr_i && addr_i == 3'h3 |=> line_format_control == $past(wdata_i))
    else $error("Line format write lost.");
endmodule

/* test/uiic_rxq_model.sv */
// Receive FIFO occupancy model standing behind the block.
`timescale 1ns/10ps
module uiic_rxq_model
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic clr_i,
  output logic [4:0] count_o
);
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i || clr_i)
      count_o <= 5'h00;
    else if (push_i && !pop_i && count_o != 5'h10)
      count_o <= count_o + 5'h01;
    else if (pop_i && !push_i && count_o != 5'h00)
      count_o <= count_o - 5'h01;
  end
endmodule

/* test/tb_top.sv */
// Self-checking testbench of the interrupt identity and format block.
`timescale 1ns/10ps
module tb_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] addr = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [3:0] ien = 4'hF;
  logic [7:0] ev = 8'h00;
  logic thr_empty = 1'b0;
  logic [4:0] cnt;
  logic fm, txc, rxc, hit, irq;
  logic [4:0] trig;
  logic [5:0] fmt;
  logic [3:0] dbits;
  logic [7:0] got;
  int n_errors = 0;
  int num_checks = 0;
  int seed = 32'h3c9a7626;
  logic [7:0] v;

  always #12.5 mclk_i = ~mclk_i;

  uiic_rxq_model partner (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .push_i(ev[5]), .pop_i(ev[4]),
    .clr_i(rxc), .count_o(cnt));

  uiic_top uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .rd_i(rd), .wr_i(wr),
    .wdata_i(wdata), .rdata_o(rdata), .irq_enable_i(ien), .line_err_i(ev[7]),
    .lsr_rd_i(ev[6]), .rx_push_i(ev[5]), .rx_pop_i(ev[4]), .rx_count_i(cnt),
    .thr_empty_i(thr_empty), .thr_wr_i(ev[3]), .modem_chg_i(ev[2]), .msr_rd_i(ev[1]),
    .char_tick_i(ev[0]), .fifo_mode_o(fm), .tx_fifo_clr_o(txc), .rx_fifo_clr_o(rxc),
    .rx_trigger_o(trig), .rx_trig_hit_o(hit), .divisor_access_select_o(fmt[5]),
    .break_ctrl_o(fmt[4]), .stick_parity_o(fmt[3]), .parity_even_o(fmt[2]),
    .parity_en_o(fmt[1]), .stop_bits_o(fmt[0]), .data_bits_o(dbits), .irq_o(irq));

  function automatic logic [4:0] trig_exp(input logic [1:0] t);
    return (t == 2'h0) ? 5'h01 : (t == 2'h1) ? 5'h04 : (t == 2'h2) ? 5'h08 : 5'h0E;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk_i);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, input logic [7:0] m, output logic [7:0] d);
    @(negedge mclk_i);
    addr = a;
    rd = 1'b1;
    ev = m;
    @(negedge mclk_i);
    rd = 1'b0;
    ev = 8'h00;
    d = rdata;
  endtask

  task automatic pulse(input logic [7:0] m);
    @(negedge mclk_i);
    ev = m;
    @(negedge mclk_i);
    ev = 8'h00;
    repeat (2) @(negedge mclk_i);
  endtask

  task automatic step(input logic [7:0] m, input logic [7:0] exp);
    pulse(m);
    rd_reg(3'h2, 8'h00, got);
    check(got, exp);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #(25 * 4000);
    n_errors++;
    stop_test();
  end

  initial
  begin
    repeat (4) @(negedge mclk_i);
    rst_n_i = 1'b1;
    rd_reg(3'h2, 8'h00, got);
    check(got, 8'h01);
    rd_reg(3'h3, 8'h00, got);
    check(got, 8'h00);
    check({7'h00, irq}, 8'h00);
    $display("test reset done");
    repeat (8)
    begin
      v = 8'($random(seed));
      wr_reg(3'h3, v);
      rd_reg(3'h3, 8'h00, got);
      check(got, v);
      check({2'h0, fmt}, {2'h0, v[7:2]});
      check({4'h0, dbits}, 8'h05 + {6'h00, v[1:0]});
    end
    $display("test format done");
    for (int t = 0; t < 4; t++)
    begin
      wr_reg(3'h2, {t[1:0], 6'h01});
      check({3'h0, trig}, {3'h0, trig_exp(t[1:0])});
      rd_reg(3'h2, 8'h00, got);
      check(got, 8'hC1);
    end
    wr_reg(3'h2, 8'h07);
    check({6'h00, txc, rxc}, 8'h03);
    @(negedge mclk_i);
    check({6'h00, txc, rxc}, 8'h00);
    wr_reg(3'h2, 8'hC0);
    check({2'h0, fm, trig}, 8'h01);
    rd_reg(3'h2, 8'h00, got);
    check(got, 8'h01);
    $display("test fifo control done");
    wr_reg(3'h2, 8'h41);
    step(8'h04, 8'hC0);
    thr_empty = 1'b1;
    step(8'h00, 8'hC2);
    step(8'h00, 8'hC0);
    rd_reg(3'h2, 8'h80, got);
    check(got, 8'hC0);
    step(8'h00, 8'hC6);
    check({7'h00, irq}, 8'h01);
    thr_empty = 1'b0;
    pulse(8'h00);
    thr_empty = 1'b1;
    step(8'h40, 8'hC2);
    thr_empty = 1'b0;
    pulse(8'h00);
    thr_empty = 1'b1;
    pulse(8'h08);
    step(8'h02, 8'hC1);
    $display("test priority done");
    pulse(8'h20);
    repeat (3) pulse(8'h01);
    step(8'h01, 8'hCC);
    step(8'h10, 8'hC1);
    repeat (3) pulse(8'h20);
    step(8'h20, 8'hC4);
    check({7'h00, hit}, 8'h01);
    step(8'h10, 8'hC1);
    check({7'h00, hit}, 8'h00);
    ien = 4'hE;
    pulse(8'h20);
    repeat (3) pulse(8'h01);
    step(8'h01, 8'hC1);
    $display("test receive done");
    stop_test();
  end
endmodule
